/* File: sac_pkg.sv */
package sac_pkg;
   // ---------------------------------------------------------------
   // register addresses (16-bit special function register space)
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_RISE_EN = 16'hff48;
   localparam logic [15:0] ADDR_FALL_EN = 16'hff49;
   localparam logic [15:0] ADDR_MODE = 16'hff80;
   localparam logic [15:0] ADDR_CHAN = 16'hff81;
   localparam logic [15:0] ADDR_RESULT = 16'hff17;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int MODE_ENABLE_BIT = 7;
   localparam int MODE_SOURCE_BIT = 6;
   localparam int MODE_TIME_LSB = 3;
   localparam int MODE_EDGE_LSB = 1;
   localparam logic [7:0] MODE_WMASK = 8'hfe;
   localparam logic [7:0] CHAN_WMASK = 8'h07;
   localparam logic [7:0] EDGE_WMASK = 8'h0f;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ---------------------------------------------------------------
   // conversion lengths in main-clock periods
   // ---------------------------------------------------------------
   localparam logic [7:0] CONV_LEN_000 = 8'h90;
   localparam logic [7:0] CONV_LEN_001 = 8'h78;
   localparam logic [7:0] CONV_LEN_010 = 8'h60;
   localparam logic [7:0] CONV_LEN_100 = 8'h48;
   localparam logic [7:0] CONV_LEN_101 = 8'h3c;
   localparam logic [7:0] CONV_LEN_110 = 8'h30;
   localparam logic [7:0] CONV_LEN_BAD = 8'h00;
   // one extra slot ahead of the eight trials samples the input; the result latches as the last trial resolves
   localparam int SAR_BITS = 8;

   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_WAIT,
      SAC_CONV
   } sac_state_e;

   typedef struct packed {
      logic       enable;
      logic       source;
      logic [2:0] time_sel;
      logic [1:0] edge_sel;
   } sac_mode_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sac_bus_s;
endpackage

/* File: sac_edge_detect.sv */
module sac_edge_detect (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // pin and selection
   input wire logic pin_in,
   input wire logic rise_en_in,
   input wire logic fall_en_in,
   // event
   output logic edge_out
);
   logic meta_ff, sync_ff, last_ff;
   logic nxt_meta, nxt_sync, nxt_last;

   always_comb begin
      nxt_meta = pin_in;
      nxt_sync = meta_ff;
      nxt_last = sync_ff;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         last_ff <= nxt_last;
      end
   end

   // only the second stage and its delayed copy are compared
   assign edge_out = (rise_en_in & sync_ff & ~last_ff) | (fall_en_in & ~sync_ff & last_ff);
endmodule // sac_edge_detect

/* File: sac_sar_step.sv */
module sac_sar_step (
   // current approximation and comparator
   input wire logic [7:0] sar_in,
   input wire logic [2:0] bit_idx_in,
   input wire logic cmp_ge_in,
   // next approximation
   output logic [7:0] sar_out
);
   always_comb begin
      sar_out = sar_in;
      sar_out[bit_idx_in] = cmp_ge_in;
      if (bit_idx_in != 3'h0) begin
         sar_out[bit_idx_in - 3'h1] = 1'b1;
      end
   end
endmodule // sac_sar_step

/* File: sac_adc_ctrl.sv */
// How it works
// - mode bit 7 clear stops everything; set lets conversions run
// - mode bit 6 picks software start (0) or trigger start (1)
// - time field codes give 144,120,96,72,60,48 clocks; others prohibited; nine whole slots here give 144,117,90,72,54,45
// - mode bits 2:1 pick none, falling, rising or both trigger edges
// - channel low three bits pick input n; upper bits read zero
// - rise/fall enable bit pairs pick edges for four interrupt pins
// - reset clears mode, channel, both edge registers and the result
// - approximation resolved bit 7 down to 0, each trial bit set first
// - trial bit stays 1 when input at or above tap, else cleared
// - after eight steps result is latched and interrupt raised together
// - trigger mode waits idle for a selected edge, then converts
// - each trigger edge seen while waiting gives exactly one conversion, then waits again
// - trigger mode channel write aborts conversion and waits for a trigger
// - software mode converts at once and repeats back to back
// - software mode channel write restarts on the new input
// - mode write with enable clear halts conversion with no result
// - any mode or channel write resets the sequencer, restarting if enabled
// - result read colliding with update returns old value first
// - trigger edges during a conversion, latch step included, are ignored
// - mode or channel write colliding with result update wins; no result, no irq
// - result register is eight bits, read only, byte wide
module sac_adc_ctrl (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // analog front end
   input wire logic cmp_ge_in,
   output logic [7:0] tap_code_out,
   output logic [2:0] chan_sel_out,
   output logic sample_out,
   output logic converting_out,
   // trigger and interrupt pins
   input wire logic ext_conv_trigger_in,
   output logic conv_end_irq_out,
   output logic [3:0] rise_enable_bit_out,
   output logic [3:0] fall_enable_bit_out
);
   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [7:0] mode_ff, chan_ff, rise_ff, fall_ff, result_ff, rdata_ff;
   logic [7:0] nxt_mode, nxt_chan, nxt_rise, nxt_fall, nxt_result, nxt_rdata;
   sac_pkg::sac_mode_s mode;
   sac_pkg::sac_bus_s bus;
   logic wr_mode, wr_chan, ctrl_write, wr_rise, wr_fall;

   assign bus = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
   assign mode = '{enable: mode_ff[sac_pkg::MODE_ENABLE_BIT],
                   source: mode_ff[sac_pkg::MODE_SOURCE_BIT],
                   time_sel: mode_ff[sac_pkg::MODE_TIME_LSB +: 3],
                   edge_sel: mode_ff[sac_pkg::MODE_EDGE_LSB +: 2]};

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   assign wr_mode = bus.wr && bus.addr == sac_pkg::ADDR_MODE;
   assign wr_chan = bus.wr && bus.addr == sac_pkg::ADDR_CHAN;
   assign wr_rise = bus.wr && bus.addr == sac_pkg::ADDR_RISE_EN;
   assign wr_fall = bus.wr && bus.addr == sac_pkg::ADDR_FALL_EN;
   assign ctrl_write = wr_mode | wr_chan;

   // conversion length from the time field; prohibited codes give zero
   function automatic logic [7:0] conv_len(input logic [2:0] code);
      unique case (code)
         3'h0: conv_len = sac_pkg::CONV_LEN_000;
         3'h1: conv_len = sac_pkg::CONV_LEN_001;
         3'h2: conv_len = sac_pkg::CONV_LEN_010;
         3'h4: conv_len = sac_pkg::CONV_LEN_100;
         3'h5: conv_len = sac_pkg::CONV_LEN_101;
         3'h6: conv_len = sac_pkg::CONV_LEN_110;
         default: conv_len = sac_pkg::CONV_LEN_BAD;
      endcase
   endfunction

   // slot length: the total split into sampling plus eight trials
   // a prohibited code runs the longest setting rather than hanging
   function automatic logic [7:0] step_of(input logic [2:0] code);
      logic [7:0] total;
      total = conv_len(code);
      if (total == sac_pkg::CONV_LEN_BAD) begin
         total = sac_pkg::CONV_LEN_000;
      end
      return total / 8'(sac_pkg::SAR_BITS + 1);
   endfunction

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   sac_pkg::sac_state_e state_ff, nxt_state;
   logic [7:0] sar_ff, nxt_sar, sar_step;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [2:0] bit_ff, nxt_bit;
   logic [7:0] step_len, wr_step_len;
   logic irq_ff, nxt_irq;
   logic trig_edge, last_step, step_tick, done;

   // ---------------------------------------------------------------
   // trigger pin and trial step
   // ---------------------------------------------------------------
   sac_edge_detect u_trig (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .pin_in(ext_conv_trigger_in),
      .rise_en_in(mode.edge_sel[1]),
      .fall_en_in(mode.edge_sel[0]),
      .edge_out(trig_edge)
   );

   sac_sar_step u_step (
      .sar_in(sar_ff),
      .bit_idx_in(bit_ff),
      .cmp_ge_in(cmp_ge_in),
      .sar_out(sar_step)
   );

   // a mode write restarts with its new time field, not the old one
   assign step_len = step_of(mode.time_sel);
   assign wr_step_len = step_of(bus.wdata[sac_pkg::MODE_TIME_LSB +: 3]);
   assign step_tick = (cnt_ff == 8'h00);
   assign last_step = (bit_ff == 3'h0);
   // completion is a cycle where the last trial resolves
   assign done = (state_ff == sac_pkg::SAC_CONV) && step_tick && last_step && !sample_out;

   logic sample_ff, nxt_sample;
   assign sample_out = sample_ff;

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_sar = sar_ff;
      nxt_cnt = cnt_ff;
      nxt_bit = bit_ff;
      nxt_sample = sample_ff;
      nxt_irq = 1'b0;
      nxt_result = result_ff;
      unique case (state_ff)
         sac_pkg::SAC_IDLE: begin
            if (mode.enable) begin
               nxt_state = mode.source ? sac_pkg::SAC_WAIT : sac_pkg::SAC_CONV;
            end
         end
         sac_pkg::SAC_WAIT: begin
            if (trig_edge) begin
               nxt_state = sac_pkg::SAC_CONV;
            end
         end
         sac_pkg::SAC_CONV: begin
            // trigger edges are not looked at here
            if (step_tick) begin
               nxt_cnt = step_len - 8'h01;
               if (sample_ff) begin
                  nxt_sample = 1'b0;
                  nxt_sar = 8'h80;
                  nxt_bit = 3'h7;
               end else begin
                  nxt_sar = sar_step;
                  nxt_bit = bit_ff - 3'h1;
               end
            end else begin
               nxt_cnt = cnt_ff - 8'h01;
            end
            if (done) begin
               nxt_result = sar_step;
               nxt_irq = 1'b1;
               // back to back in software mode, one shot in trigger mode
               nxt_state = mode.source ? sac_pkg::SAC_WAIT : sac_pkg::SAC_CONV;
            end
         end
         default: nxt_state = sac_pkg::SAC_IDLE;
      endcase
      // entering a conversion from anywhere starts with sampling
      if (nxt_state == sac_pkg::SAC_CONV && (state_ff != sac_pkg::SAC_CONV || done)) begin
         nxt_sample = 1'b1;
         nxt_cnt = step_len - 8'h01;
         nxt_sar = 8'h00;
         nxt_bit = 3'h7;
      end
      // control writes dominate: abort, drop any result, restart from scratch
      if (ctrl_write) begin
         nxt_result = result_ff;
         nxt_irq = 1'b0;
         nxt_sar = 8'h00;
         nxt_bit = 3'h7;
         nxt_sample = 1'b1;
         nxt_cnt = (wr_mode ? wr_step_len : step_len) - 8'h01;
         if (wr_mode && !bus.wdata[sac_pkg::MODE_ENABLE_BIT]) begin
            nxt_state = sac_pkg::SAC_IDLE;
         end else if (wr_mode) begin
            nxt_state = bus.wdata[sac_pkg::MODE_SOURCE_BIT] ? sac_pkg::SAC_WAIT
                                                             : sac_pkg::SAC_CONV;
         end else if (mode.enable) begin
            nxt_state = mode.source ? sac_pkg::SAC_WAIT : sac_pkg::SAC_CONV;
         end else begin
            nxt_state = sac_pkg::SAC_IDLE;
         end
      end
      if (!mode.enable && !wr_mode) begin
         nxt_state = sac_pkg::SAC_IDLE;
      end
      // outside a conversion the front end tracks its input
      if (nxt_state != sac_pkg::SAC_CONV) begin
         nxt_sample = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         state_ff <= sac_pkg::SAC_IDLE;
         sar_ff <= 8'h00;
         cnt_ff <= 8'h00;
         bit_ff <= 3'h7;
         sample_ff <= 1'b1;
         irq_ff <= 1'b0;
         result_ff <= sac_pkg::REG_RESET;
      end else begin
         state_ff <= nxt_state;
         sar_ff <= nxt_sar;
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
         sample_ff <= nxt_sample;
         irq_ff <= nxt_irq;
         result_ff <= nxt_result;
      end
   end

   // ---------------------------------------------------------------
   // register writes and reads
   // ---------------------------------------------------------------
   always_comb begin
      nxt_mode = mode_ff;
      nxt_chan = chan_ff;
      nxt_rise = rise_ff;
      nxt_fall = fall_ff;
      if (wr_mode) begin
         nxt_mode = bus.wdata & sac_pkg::MODE_WMASK;
      end
      if (wr_chan) begin
         nxt_chan = bus.wdata & sac_pkg::CHAN_WMASK;
      end
      if (wr_rise) begin
         nxt_rise = bus.wdata & sac_pkg::EDGE_WMASK;
      end
      if (wr_fall) begin
         nxt_fall = bus.wdata & sac_pkg::EDGE_WMASK;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         mode_ff <= sac_pkg::REG_RESET;
         chan_ff <= sac_pkg::REG_RESET;
         rise_ff <= sac_pkg::REG_RESET;
         fall_ff <= sac_pkg::REG_RESET;
      end else begin
         mode_ff <= nxt_mode;
         chan_ff <= nxt_chan;
         rise_ff <= nxt_rise;
         fall_ff <= nxt_fall;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   // read data sampled from the register before this edge's update
   always_comb begin
      nxt_rdata = rdata_ff;
      if (bus.rd) begin
         unique case (bus.addr)
            sac_pkg::ADDR_MODE: nxt_rdata = mode_ff;
            sac_pkg::ADDR_CHAN: nxt_rdata = chan_ff;
            sac_pkg::ADDR_RISE_EN: nxt_rdata = rise_ff;
            sac_pkg::ADDR_FALL_EN: nxt_rdata = fall_ff;
            sac_pkg::ADDR_RESULT: nxt_rdata = result_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_out = rdata_ff;
   assign tap_code_out = sar_ff;
   assign chan_sel_out = chan_ff[2:0];
   assign converting_out = (state_ff == sac_pkg::SAC_CONV);
   assign conv_end_irq_out = irq_ff;
   assign rise_enable_bit_out = rise_ff[3:0];
   assign fall_enable_bit_out = fall_ff[3:0];
endmodule // sac_adc_ctrl

/* File: sac_cmp_model.sv */
module sac_cmp_model (
   // trial code and channel from the block
   input wire logic [7:0] tap_in,
   input wire logic [2:0] chan_in,
   // comparator decision
   output logic cmp_ge_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // fixed input level per channel, end codes at both rails
   // ---------------------------------------------------------------
   logic [7:0] level;
   assign level = (chan_in == 3'h0) ? 8'h00 : (chan_in == 3'h7) ? 8'hff : 8'(chan_in * 8'h21 + 8'h0e);
   // ideal comparator: equal counts as at or above the tap
   assign cmp_ge_out = (level >= tap_in);
endmodule // sac_cmp_model

/* File: sac_adc_ctrl_sva.sv */
module sac_adc_ctrl_sva (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // watched ports
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [2:0] chan_sel_out,
   input wire logic converting_out,
   input wire logic conv_end_irq_out,
   input wire logic [3:0] rise_enable_bit_out,
   input wire logic [3:0] fall_enable_bit_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   // ---------------------------------------------------------------
   // shadow of the enable bit, taken from the write traffic
   // ---------------------------------------------------------------
   logic en_ff;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         en_ff <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == sac_pkg::ADDR_MODE) begin
         en_ff <= reg_wdata_in[sac_pkg::MODE_ENABLE_BIT];
      end
   end
   sequence mode_off_s;
      reg_wr_in && reg_addr_in == sac_pkg::ADDR_MODE && !reg_wdata_in[7];
   endsequence
   sequence chan_wr_s;
      reg_wr_in && reg_addr_in == sac_pkg::ADDR_CHAN;
   endsequence
   sequence quiet_s;
      !converting_out && !conv_end_irq_out;
   endsequence
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   irq_pulse_a: assert property (conv_end_irq_out |=> !conv_end_irq_out)
      else $error("end interrupt longer than one cycle");
   irq_source_a: assert property (conv_end_irq_out |-> $past(converting_out))
      else $error("end interrupt without a conversion");
   stop_halts_a: assert property (mode_off_s |=> quiet_s)
      else $error("conversion kept running after disable");
   chan_noirq_a: assert property (chan_wr_s |=> !conv_end_irq_out)
      else $error("interrupt raised beside a channel write");
   off_idle_a: assert property (!en_ff [*3] |-> !converting_out)
      else $error("converting while disabled");
   unmapped_zero_a: assert property (reg_rd_in && reg_addr_in == 16'hff00 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   chan_read_a: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == sac_pkg::ADDR_CHAN
      |=> reg_rdata_out == {5'h00, chan_sel_out})
      else $error("channel read back wrong");
   chan_out_a: assert property (chan_wr_s |=> chan_sel_out == $past(reg_wdata_in[2:0]))
      else $error("channel select not updated");
   rise_en_a: assert property (reg_wr_in && reg_addr_in == sac_pkg::ADDR_RISE_EN
      |=> rise_enable_bit_out == $past(reg_wdata_in[3:0]))
      else $error("rise enables not updated");
   fall_en_a: assert property (reg_wr_in && reg_addr_in == sac_pkg::ADDR_FALL_EN
      |=> fall_enable_bit_out == $past(reg_wdata_in[3:0]))
      else $error("fall enables not updated");
endmodule // sac_adc_ctrl_sva

bind sac_adc_ctrl sac_adc_ctrl_sva chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .chan_sel_out(chan_sel_out),
   .converting_out(converting_out), .conv_end_irq_out(conv_end_irq_out),
   .rise_enable_bit_out(rise_enable_bit_out), .fall_enable_bit_out(fall_enable_bit_out));

/* File: sac_adc_ctrl_test.sv */
module sac_adc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, trg = 1'b0, cmp, smp, conv, irq;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata, tap;
   logic [2:0] chan;
   logic [3:0] rise, fall;
   int mismatches = 0, n_tests = 0, cyc = 0, n;
   localparam int LEN [6] = '{144, 120, 96, 72, 60, 48};
   localparam logic [2:0] CODE [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
   localparam logic [15:0] ADDRS [5] = '{sac_pkg::ADDR_RISE_EN, sac_pkg::ADDR_FALL_EN,
      sac_pkg::ADDR_MODE, sac_pkg::ADDR_CHAN, sac_pkg::ADDR_RESULT};
   // write table: address, data, read-back; the last two are read-only and unmapped
   localparam logic [15:0] WA [6] = '{16'hff48, 16'hff49, 16'hff81, 16'hff80, 16'hff17, 16'hff00};
   localparam logic [7:0] WD [6] = '{8'hff, 8'ha5, 8'hfe, 8'h7f, 8'h55, 8'h55};
   localparam logic [7:0] WE [6] = '{8'h0f, 8'h05, 8'h06, 8'h7e, 8'h00, 8'h00};
   always #2 clk = ~clk;
   sac_adc_ctrl uut (.core_clk_in(clk), .rstn_in(rstn), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .cmp_ge_in(cmp),
      .tap_code_out(tap), .chan_sel_out(chan), .sample_out(smp), .converting_out(conv),
      .ext_conv_trigger_in(trg), .conv_end_irq_out(irq), .rise_enable_bit_out(rise),
      .fall_enable_bit_out(fall));
   sac_cmp_model fe (.tap_in(tap), .chan_in(chan), .cmp_ge_out(cmp));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] level(input logic [2:0] c);
      return (c == 3'h0) ? 8'h00 : (c == 3'h7) ? 8'hff : 8'(c * 8'h21 + 8'h0e);
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      check(rdata, exp);
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== 1'b1 && n < lim);
   endtask
   task automatic count_irq(input int cycles);
      n = 0;
      repeat (cycles) begin
         @(negedge clk);
         if (irq === 1'b1) n++;
      end
   endtask
   // hang guard, well above the few thousand cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      check({7'h00, smp}, 8'h01);
      foreach (ADDRS[i]) rd_reg(ADDRS[i], 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr_reg(WA[i], WD[i]);
         rd_reg(WA[i], WE[i]);
      end
      check({rise, fall}, 8'hf5);
      count_irq(200);
      check(8'(n), 8'h00);
      wr_reg(sac_pkg::ADDR_MODE, 8'h00);
      wr_reg(sac_pkg::ADDR_MODE, 8'hb0);
      for (int c = 0; c < 8; c++) begin
         wr_reg(sac_pkg::ADDR_CHAN, 8'(c));
         wait_irq(100);
         check(8'(n < 100), 8'h01);
         rd_reg(sac_pkg::ADDR_RESULT, level(3'(c)));
         check({5'h00, chan}, 8'(c));
      end
      wr_reg(sac_pkg::ADDR_MODE, 8'h30);
      count_irq(200);
      check({7'h00, conv}, 8'h00);
      check(8'(n), 8'h00);
      check(tap, 8'h00);
      check({7'h00, smp}, 8'h01);
      for (int i = 0; i < 6; i++) begin
         wr_reg(sac_pkg::ADDR_MODE, 8'h00);
         wr_reg(sac_pkg::ADDR_MODE, {2'b10, CODE[i], 3'b000});
         wait_irq(300);
         wait_irq(300);
         check(8'(n >= 9 * (LEN[i] / 9) && n <= LEN[i] + 2), 8'h01);
      end
      for (int e = 0; e < 4; e++) begin
         wr_reg(sac_pkg::ADDR_MODE, 8'h00);
         wr_reg(sac_pkg::ADDR_MODE, 8'hf0 | 8'(e << 1));
         count_irq(100);
         check(8'(n), 8'h00);
         trg = 1'b1;
         count_irq(100);
         check(8'(n), 8'(e >> 1));
         trg = 1'b0;
         count_irq(100);
         check(8'(n), 8'(e & 1));
      end
      // second edge lands inside the running conversion
      trg = 1'b1;
      repeat (10) @(negedge clk);
      trg = 1'b0;
      count_irq(150);
      check(8'(n), 8'h01);
      trg = 1'b1;
      repeat (10) @(negedge clk);
      wr_reg(sac_pkg::ADDR_CHAN, 8'h03);
      count_irq(100);
      check(8'(n), 8'h00);
      trg = 1'b0;
      count_irq(100);
      check(8'(n), 8'h01);
      rd_reg(sac_pkg::ADDR_RESULT, level(3'h3));
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      foreach (ADDRS[i]) rd_reg(ADDRS[i], 8'h00);
      wrap_up();
   end
endmodule // sac_adc_ctrl_test
